// ### rtl/bsf_pkg.sv
/*
  constants for the brake sequence fault supervisor: register offsets,
  field positions, reset values, fault codes and timing figures.
  assumes a 10 MHz control clock and frequencies in 0.01 Hz units.
*/
`default_nettype none

package bsf_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
  localparam int unsigned TIMEOUT_S       = 2;
  localparam logic [11:0] TIMEOUT_MS      = 12'(TIMEOUT_S * MS_PER_S);

  // frequency floor for shutoff, 0.01 Hz units (0.5 Hz)
  localparam logic [15:0] FREQ_FLOOR      = 16'h0032;

  // ramp selection values that enable the brake sequence
  localparam logic [3:0]  MODE_BRAKE_FB   = 4'h7;
  localparam logic [3:0]  MODE_BRAKE_NOFB = 4'h8;

  // register offsets (byte addresses)
  localparam logic [7:0]  OFS_MODE        = 8'h00;
  localparam logic [7:0]  OFS_START_FREQ  = 8'h04;
  localparam logic [7:0]  OFS_OPEN_FREQ   = 8'h08;
  localparam logic [7:0]  OFS_OPER_FREQ   = 8'h0c;
  localparam logic [7:0]  OFS_DWELL       = 8'h10;
  localparam logic [7:0]  OFS_STATUS      = 8'h14;
  localparam logic [7:0]  OFS_MASK        = 8'h18;
  localparam logic [7:0]  OFS_STATE       = 8'h1c;

  // reset values
  localparam logic [3:0]  RST_MODE        = 4'h0;
  localparam logic [15:0] RST_START_FREQ  = 16'h0032;
  localparam logic [15:0] RST_OPEN_FREQ   = 16'h012c;
  localparam logic [15:0] RST_OPER_FREQ   = 16'h0258;
  localparam logic [11:0] RST_DWELL       = 12'h12c;
  localparam logic [4:0]  RST_MASK        = 5'h00;

  // status / mask bit positions
  localparam int unsigned ST_REQ_TMO      = 0;
  localparam int unsigned ST_FB_TMO       = 1;
  localparam int unsigned ST_FB_LOST      = 2;
  localparam int unsigned ST_FB_STUCK     = 3;
  localparam int unsigned ST_SHUTOFF      = 4;
  localparam int unsigned ST_W            = 5;

  // state register field positions
  localparam int unsigned SR_CODE_LSB     = 0;
  localparam int unsigned SR_TRIP         = 4;
  localparam int unsigned SR_REQ          = 5;
  localparam int unsigned SR_FB           = 6;
  localparam int unsigned SR_SHUT         = 7;

  // fault codes
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_REQ_TMO    = 3'h4;
  localparam logic [2:0]  CODE_FB_TMO     = 3'h5;
  localparam logic [2:0]  CODE_FB_LOST    = 3'h6;
  localparam logic [2:0]  CODE_FB_STUCK   = 3'h7;

  typedef enum logic [2:0] {
    BSF_IDLE, BSF_WAIT_REQ, BSF_WAIT_FB, BSF_RUN, BSF_STOP_WAIT, BSF_TRIP
  } bsf_state_t;

endpackage : bsf_pkg

`default_nettype wire

// ### rtl/bsf_supervisor.sv
/*
  brake sequence fault supervisor: drives the brake release request,
  watches the release feedback, trips on handshake faults and shuts the
  output off at the low frequency floor while decelerating.
  assumes all inputs but rstn synchronous to clk and a plain register port whose
  read data is presented one cycle after the read strobe.
*/
// Local design decisions: the strobed register port and the register addresses.
`default_nettype none

module bsf_supervisor
  import bsf_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        rstn,
  // register port
  input  wire  logic [7:0]  addr,
  input  wire  logic [31:0] wdata,
  input  wire  logic        wr,
  input  wire  logic        rd,
  output logic       [31:0] rdata,
  // drive status
  input  wire  logic        start_fwd,
  input  wire  logic        start_rev,
  input  wire  logic        decelerating,
  input  wire  logic        current_ok,
  input  wire  logic [15:0] speed_cmd,
  input  wire  logic [15:0] output_freq,
  // brake handshake
  input  wire  logic        brake_released_feedback,
  output logic              brake_release_request,
  // fault outputs
  output logic              trip,
  output logic              output_shutoff,
  output logic        [2:0] fault_code,
  output logic              irq
);

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  bsf_state_t  state_ff, nxt_state;
  logic [3:0]  automatic_ramp_selection_ff;
  logic [15:0] starting_frequency_setting_ff;
  logic [15:0] brake_opening_frequency_setting_ff;
  logic [15:0] brake_operation_frequency_ff;
  logic [11:0] current_detection_dwell_setting_ff;
  logic [ST_W-1:0] status_ff, mask_ff, events;
  logic [13:0] div_ff;
  logic        ms_tick;
  logic [11:0] timer_ff;
  logic [11:0] dwell_ff;
  logic        cond_ff;
  logic        req_ff, trip_ff, shut_ff, irq_ff;
  logic [2:0]  code_ff, nxt_code;
  logic [31:0] rdata_ff;
  logic        brake_mode, fb_mode, start_cmd, open_cond, timed_out;
  logic [12:0] ramp_plus_dwell;
  logic [15:0] floor_freq;
  logic        shut_now;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign brake_mode = (automatic_ramp_selection_ff == MODE_BRAKE_FB) ||
                      (automatic_ramp_selection_ff == MODE_BRAKE_NOFB);
  assign fb_mode    = automatic_ramp_selection_ff == MODE_BRAKE_FB;
  assign start_cmd  = start_fwd | start_rev;
  assign open_cond  = (speed_cmd >= brake_opening_frequency_setting_ff) &&
                      current_ok;
  assign ms_tick    = div_ff == 14'(MS_CYCLES - 1);
  // strictly more than 2 s: the tick after the count reached the limit
  assign timed_out  = ms_tick && (timer_ff == TIMEOUT_MS);
  assign ramp_plus_dwell = {1'b0, timer_ff} +
                           {1'b0, current_detection_dwell_setting_ff};

  // millisecond divider, restarted with every phase change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 14'h0;
    end else if (state_ff != nxt_state || ms_tick) begin
      div_ff <= 14'h0;
    end else begin
      div_ff <= div_ff + 14'h1;
    end
  end

  // phase timer restarts on the edge that opens each supervised phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= 12'h0;
    end else if (state_ff != nxt_state) begin
      timer_ff <= 12'h0;
    end else if (ms_tick && timer_ff != TIMEOUT_MS) begin
      timer_ff <= timer_ff + 12'h1;
    end
  end

  // dwell counter runs while speed and current both qualify
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_ff <= 12'h0;
      cond_ff  <= 1'b0;
    end else begin
      cond_ff <= (state_ff == BSF_WAIT_REQ) && open_cond;
      if (state_ff != BSF_WAIT_REQ || !open_cond) begin
        dwell_ff <= 12'h0;
      end else if (ms_tick && dwell_ff != 12'hfff) begin
        dwell_ff <= dwell_ff + 12'h1;
      end
    end
  end

  // sequence and fault detection
  always_comb begin
    nxt_state = state_ff;
    nxt_code  = CODE_NONE;
    unique case (state_ff)
      BSF_IDLE: begin
        if (brake_mode && start_cmd && !decelerating) begin
          nxt_state = BSF_WAIT_REQ;
        end
      end
      BSF_WAIT_REQ: begin
        if (!brake_mode || !start_cmd) begin
          nxt_state = BSF_IDLE;
        end else if (open_cond && !cond_ff &&
                     ramp_plus_dwell > {1'b0, TIMEOUT_MS}) begin
          nxt_code = CODE_REQ_TMO;
        end else if (timed_out) begin
          nxt_code = CODE_REQ_TMO;
        end else if (open_cond &&
                     dwell_ff >= current_detection_dwell_setting_ff) begin
          nxt_state = fb_mode ? BSF_WAIT_FB : BSF_RUN;
        end
      end
      BSF_WAIT_FB: begin
        if (!fb_mode) begin
          nxt_state = BSF_IDLE;
        end else if (timed_out) begin
          nxt_code = CODE_FB_TMO;
        end else if (brake_released_feedback) begin
          nxt_state = BSF_RUN;
        end
      end
      BSF_RUN: begin
        if (fb_mode && !brake_released_feedback) begin
          nxt_code = CODE_FB_LOST;
        end else if (decelerating &&
                     output_freq <= brake_operation_frequency_ff) begin
          nxt_state = BSF_STOP_WAIT;
        end
      end
      BSF_STOP_WAIT: begin
        if (!fb_mode || !brake_released_feedback) begin
          nxt_state = BSF_IDLE;
        end else if (timed_out) begin
          nxt_code = CODE_FB_STUCK;
        end
      end
      BSF_TRIP: begin
        nxt_state = BSF_TRIP;
      end
    endcase
    if (nxt_code != CODE_NONE) begin
      nxt_state = BSF_TRIP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= BSF_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // request, trip and held fault code; only reset clears a trip
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff  <= 1'b0;
      trip_ff <= 1'b0;
      code_ff <= CODE_NONE;
    end else begin
      req_ff <= (nxt_state == BSF_WAIT_FB) || (nxt_state == BSF_RUN);
      if (nxt_code != CODE_NONE && !trip_ff) begin
        trip_ff <= 1'b1;
        code_ff <= nxt_code;
      end
    end
  end

  // low frequency shutoff while decelerating
  assign floor_freq = (starting_frequency_setting_ff < FREQ_FLOOR) ?
                      starting_frequency_setting_ff : FREQ_FLOOR;
  assign shut_now   = decelerating && output_freq <= floor_freq;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shut_ff <= 1'b0;
    end else if (shut_now || nxt_code != CODE_NONE || trip_ff) begin
      shut_ff <= 1'b1;
    end else if (start_cmd && !decelerating) begin
      shut_ff <= 1'b0;
    end
  end

  // status events; a set in the same cycle as its clear wins
  generate
    for (genvar i = 0; i < ST_W - 1; i++) begin : g_ev
      assign events[i] = (nxt_code == 3'(CODE_REQ_TMO + 3'(i))) &&
                         !trip_ff;
    end
  endgenerate
  assign events[ST_SHUTOFF] = shut_now && !shut_ff;

  // configuration registers written from the port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      automatic_ramp_selection_ff        <= RST_MODE;
      starting_frequency_setting_ff      <= RST_START_FREQ;
      brake_opening_frequency_setting_ff <= RST_OPEN_FREQ;
      brake_operation_frequency_ff       <= RST_OPER_FREQ;
      current_detection_dwell_setting_ff <= RST_DWELL;
      mask_ff                            <= RST_MASK;
    end else if (wr) begin
      unique case (addr)
        OFS_MODE:       automatic_ramp_selection_ff <= wdata[3:0];
        OFS_START_FREQ: starting_frequency_setting_ff <= wdata[15:0];
        OFS_OPEN_FREQ:  brake_opening_frequency_setting_ff <= wdata[15:0];
        OFS_OPER_FREQ:  brake_operation_frequency_ff <= wdata[15:0];
        OFS_DWELL:      current_detection_dwell_setting_ff <= wdata[11:0];
        OFS_MASK:       mask_ff <= wdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= '0;
    end else if (wr && addr == OFS_STATUS) begin
      status_ff <= (status_ff & ~wdata[ST_W-1:0]) | events;
    end else begin
      status_ff <= status_ff | events;
    end
  end

  // level interrupt from registered status and mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= 32'h0;
      if (rd) begin
        unique case (addr)
          OFS_MODE:       rdata_ff <= {28'h0, automatic_ramp_selection_ff};
          OFS_START_FREQ: rdata_ff <= {16'h0, starting_frequency_setting_ff};
          OFS_OPEN_FREQ:  rdata_ff <= {16'h0,
                                       brake_opening_frequency_setting_ff};
          OFS_OPER_FREQ:  rdata_ff <= {16'h0, brake_operation_frequency_ff};
          OFS_DWELL:      rdata_ff <= {20'h0,
                                       current_detection_dwell_setting_ff};
          OFS_STATUS:     rdata_ff <= {27'h0, status_ff};
          OFS_MASK:       rdata_ff <= {27'h0, mask_ff};
          OFS_STATE: begin
            rdata_ff <= {24'h0, shut_ff, brake_released_feedback, req_ff,
                         trip_ff, 1'b0, code_ff};
          end
          default:        rdata_ff <= 32'h0;
        endcase
      end
    end
  end

  assign brake_release_request = req_ff;
  assign trip                  = trip_ff;
  assign output_shutoff        = shut_ff;
  assign fault_code            = code_ff;
  assign irq                   = irq_ff;
  assign rdata                 = rdata_ff;

endmodule : bsf_supervisor

`default_nettype wire

// ### bench/bsf_sup_props.sv
/*
  port checker for bsf_supervisor, bound to every instance.
  assumes settings change only by the write strobe.
*/
`default_nettype none
module bsf_sup_props
  import bsf_pkg::*;
#(parameter int unsigned MS_CYCLES = CYC_PER_MS) (
  // every port of the supervisor, seen as inputs
  input wire logic        clk, rstn, wr, rd, start_fwd, start_rev,
  input wire logic        decelerating, current_ok, irq, trip,
  input wire logic        brake_released_feedback, brake_release_request,
  input wire logic        output_shutoff,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata, rdata,
  input wire logic [15:0] speed_cmd, output_freq,
  input wire logic [2:0]  fault_code
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO_MAX = 2002 * MS_CYCLES + 8;
  logic [3:0]  mode_ff;
  logic [15:0] start_ff, open_ff, floor;
  int          wait_ff;
  logic        sup;
  assign sup = mode_ff == MODE_BRAKE_FB || mode_ff == MODE_BRAKE_NOFB;
  assign floor = (start_ff < FREQ_FLOOR) ? start_ff : FREQ_FLOOR;
  // shadow copies of the settings the rules depend on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff  <= RST_MODE;
      start_ff <= RST_START_FREQ;
      open_ff  <= RST_OPEN_FREQ;
    end else if (wr) begin
      if (addr == OFS_MODE) mode_ff <= wdata[3:0];
      if (addr == OFS_START_FREQ) start_ff <= wdata[15:0];
      if (addr == OFS_OPEN_FREQ) open_ff <= wdata[15:0];
    end
  end
  // a counter bounds the feedback wait; a delay range would be too long
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wait_ff <= 0;
    else if (brake_release_request && !brake_released_feedback &&
             mode_ff == MODE_BRAKE_FB) wait_ff <= wait_ff + 1;
    else wait_ff <= 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence trip_on;
    $rose(trip);
  endsequence
  sequence fb_drop;
    mode_ff == MODE_BRAKE_FB && brake_release_request &&
      $fell(brake_released_feedback);
  endsequence
  req_off_trip_a: assert property (trip |-> !brake_release_request)
    else $error("request high while tripped");
  trip_hold_a: assert property (trip |=> trip && $stable(fault_code))
    else $error("trip or code changed before reset");
  code_trip_a: assert property (trip == (fault_code != CODE_NONE))
    else $error("trip and fault code disagree");
  shut_trip_a: assert property (trip_on |-> ##[0:1] output_shutoff)
    else $error("output not shut off on trip");
  trip_mode_a: assert property (trip_on |-> $past(sup))
    else $error("trip outside brake sequence mode");
  shut_floor_a: assert property (sup && decelerating &&
    output_freq <= floor |-> ##[1:2] output_shutoff)
    else $error("no shutoff at frequency floor");
  fb_lost_a: assert property (fb_drop |-> ##[0:2] trip)
    else $error("feedback loss did not trip");
  req_cause_a: assert property ($rose(brake_release_request) |->
    $past(sup) && $past(current_ok) && $past(speed_cmd) >= open_ff)
    else $error("request without opening condition");
  fb_wait_a: assert property (wait_ff <= TMO_MAX)
    else $error("feedback wait beyond timeout");
  rd_idle_a: assert property (!$past(rd) || $past(addr) > OFS_STATE
    |-> rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : bsf_sup_props

bind bsf_supervisor bsf_sup_props #(.MS_CYCLES(MS_CYCLES)) i_bsf_sup_props (
  .clk(clk), .rstn(rstn), .wr(wr), .rd(rd), .start_fwd(start_fwd),
  .start_rev(start_rev), .decelerating(decelerating), .irq(irq),
  .current_ok(current_ok), .trip(trip), .output_shutoff(output_shutoff),
  .brake_released_feedback(brake_released_feedback), .addr(addr),
  .brake_release_request(brake_release_request), .wdata(wdata),
  .rdata(rdata), .speed_cmd(speed_cmd), .output_freq(output_freq),
  .fault_code(fault_code));
`default_nettype wire

// ### bench/bsf_brake_model.sv
/*
  brake with a release contact: follows the request after a delay,
  or misbehaves as behave selects (1 never opens, 2 drops, 3 sticks).
  assumes behave is changed only while the supervisor is in reset.
*/
`default_nettype none
module bsf_brake_model #(parameter int unsigned DELAY = 8) (
  // clock, reset and request from the supervisor
  input wire logic       clk, rstn, brake_release_request,
  // fault selection from the bench
  input wire logic [1:0] behave,
  // release contact
  output logic           brake_released_feedback
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        req_q;
  int unsigned age;
  // cycles since the request last changed
  always @(posedge clk) begin
    req_q <= brake_release_request;
    age <= (brake_release_request == req_q) ? age + 1 : 0;
  end
  // the contact moves only after the mechanical delay
  always @(posedge clk or negedge rstn) begin
    if (!rstn) brake_released_feedback <= 1'b0;
    else if (age == DELAY) begin
      case (behave)
        2'h1: brake_released_feedback <= 1'b0;
        // a stuck contact never lets go once it has opened
        2'h3: begin
          brake_released_feedback <= req_q | brake_released_feedback;
        end
        default: brake_released_feedback <= req_q;
      endcase
    end else if (behave == 2'h2 && req_q && age == 3 * DELAY)
      brake_released_feedback <= 1'b0;
  end
endmodule : bsf_brake_model
`default_nettype wire

// ### bench/tb_bsf_supervisor.sv
/*
  self-checking bench for bsf_supervisor with the brake model.
  assumes MS_CYCLES of 4, so 2 s is about 8000 cycles.
*/
`default_nettype none
module tb_bsf_supervisor import bsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn, wr, rd, start_fwd, start_rev, decelerating, current_ok, irq;
  logic brake_released_feedback, brake_release_request, trip;
  logic output_shutoff;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [15:0] speed_cmd, output_freq;
  logic [2:0] fault_code;
  logic [1:0] behave;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  bsf_supervisor #(.MS_CYCLES(4)) i_bsf_supervisor (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .start_fwd(start_fwd), .start_rev(start_rev), .current_ok(current_ok),
    .decelerating(decelerating), .speed_cmd(speed_cmd), .irq(irq),
    .output_freq(output_freq), .trip(trip), .fault_code(fault_code),
    .brake_released_feedback(brake_released_feedback),
    .brake_release_request(brake_release_request),
    .output_shutoff(output_shutoff));
  bsf_brake_model i_bsf_brake_model (.clk(clk), .rstn(rstn),
    .brake_release_request(brake_release_request), .behave(behave),
    .brake_released_feedback(brake_released_feedback));
  task automatic stop_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    check(v, exp);
  endtask : chk_reg
  task automatic go(logic [3:0] m, logic [1:0] b, logic cur, logic rev,
                    logic [11:0] dw);
    @(posedge clk);
    rstn <= 1'b0;
    behave <= b;
    {start_fwd, start_rev, decelerating, current_ok} <= 4'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(OFS_MODE, 32'(m));
    wr_reg(OFS_DWELL, 32'(dw));
    wr_reg(OFS_MASK, 32'h1);
    // opening frequency left at its 3 Hz reset value, above 0.5 Hz
    speed_cmd <= RST_OPEN_FREQ;
    output_freq <= RST_OPEN_FREQ;
    current_ok <= cur;
    start_fwd <= !rev;
    start_rev <= rev;
  endtask : go
  task automatic wait_lvl(logic lvl);
    int n;
    n = 0;
    while (brake_release_request !== lvl && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(32'(n < 200), 32'h1);
  endtask : wait_lvl
  task automatic wait_trip(logic [2:0] c, int lo, int hi);
    int n;
    n = 0;
    while (trip !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    check(32'(n >= lo && n < hi), 32'h1);
    check(32'(fault_code), 32'(c));
    check(32'(brake_release_request), 32'h0);
  endtask : wait_trip
  task automatic t_regs();
    chk_reg(OFS_MODE, 32'(RST_MODE));
    chk_reg(OFS_START_FREQ, 32'(RST_START_FREQ));
    chk_reg(OFS_OPEN_FREQ, 32'(RST_OPEN_FREQ));
    chk_reg(OFS_OPER_FREQ, 32'(RST_OPER_FREQ));
    chk_reg(OFS_DWELL, 32'(RST_DWELL));
    chk_reg(OFS_MASK, 32'(RST_MASK));
    chk_reg(OFS_STATUS, 32'h0);
    chk_reg(OFS_STATE, 32'h0);
    chk_reg(8'h40, 32'h0);
  endtask : t_regs
  task automatic t_normal();
    go(MODE_BRAKE_FB, 2'h0, 1'b0, 1'b0, 12'h001);
    repeat (20) @(negedge clk);
    check(32'(brake_release_request), 32'h0);
    @(posedge clk);
    current_ok <= 1'b1;
    wait_lvl(1'b1);
    repeat (20) @(posedge clk);
    decelerating <= 1'b1;
    output_freq <= RST_OPER_FREQ;
    repeat (3) @(negedge clk);
    check(32'(brake_release_request), 32'h0);
    repeat (20) @(posedge clk);
    output_freq <= FREQ_FLOOR + 16'h1;
    repeat (3) @(negedge clk);
    check(32'(output_shutoff), 32'h0);
    @(posedge clk);
    output_freq <= FREQ_FLOOR;
    repeat (3) @(negedge clk);
    check(32'(output_shutoff), 32'h1);
    check(32'(trip), 32'h0);
    chk_reg(OFS_STATUS, 32'h10);
  endtask : t_normal
  task automatic t_req_tmo();
    go(MODE_BRAKE_FB, 2'h0, 1'b0, 1'b1, 12'h001);
    wait_trip(CODE_REQ_TMO, 8000, 8020);
    repeat (3) @(negedge clk);
    check(32'(irq), 32'h1);
    chk_reg(OFS_STATUS, 32'h1);
    wr_reg(OFS_STATUS, 32'h1f);
    repeat (3) @(negedge clk);
    check(32'(irq), 32'h0);
    chk_reg(OFS_STATUS, 32'h0);
    repeat (20) @(posedge clk);
    chk_reg(OFS_STATE, 32'h94);
  endtask : t_req_tmo
  task automatic t_fb_tmo();
    go(MODE_BRAKE_FB, 2'h1, 1'b1, 1'b0, 12'h001);
    wait_lvl(1'b1);
    wait_trip(CODE_FB_TMO, 8000, 8020);
  endtask : t_fb_tmo
  task automatic t_fb_lost();
    go(MODE_BRAKE_FB, 2'h2, 1'b1, 1'b0, 12'h001);
    wait_trip(CODE_FB_LOST, 20, 200);
  endtask : t_fb_lost
  task automatic t_fb_stuck();
    go(MODE_BRAKE_FB, 2'h3, 1'b1, 1'b0, 12'h001);
    wait_lvl(1'b1);
    repeat (20) @(posedge clk);
    decelerating <= 1'b1;
    output_freq <= RST_OPER_FREQ;
    wait_lvl(1'b0);
    wait_trip(CODE_FB_STUCK, 8000, 8020);
  endtask : t_fb_stuck
  task automatic t_dwell();
    go(MODE_BRAKE_FB, 2'h0, 1'b1, 1'b0, 12'h800);
    wait_trip(CODE_REQ_TMO, 0, 100);
  endtask : t_dwell
  // a start frequency below 0.5 Hz moves the shutoff point down to it
  task automatic t_floor();
    go(MODE_BRAKE_FB, 2'h0, 1'b0, 1'b0, 12'h001);
    chk_reg(OFS_MODE, 32'(MODE_BRAKE_FB));
    wr_reg(OFS_START_FREQ, 32'h20);
    chk_reg(OFS_START_FREQ, 32'h20);
    @(posedge clk);
    decelerating <= 1'b1;
    output_freq <= FREQ_FLOOR;
    repeat (3) @(negedge clk);
    check(32'(output_shutoff), 32'h0);
    @(posedge clk);
    output_freq <= 16'h20;
    repeat (3) @(negedge clk);
    check(32'(output_shutoff), 32'h1);
  endtask : t_floor
  task automatic t_modes();
    go(4'h0, 2'h1, 1'b1, 1'b0, 12'h001);
    repeat (8100) @(negedge clk);
    check(32'(trip), 32'h0);
    go(MODE_BRAKE_NOFB, 2'h1, 1'b1, 1'b0, 12'h001);
    wait_lvl(1'b1);
    repeat (8100) @(negedge clk);
    check(32'(trip), 32'h0);
  endtask : t_modes
  // main sequence
  initial begin
    {rstn, wr, rd, start_fwd, start_rev, decelerating, current_ok} = 7'h0;
    {addr, wdata, speed_cmd, output_freq, behave} = 74'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_normal();
    t_req_tmo();
    t_fb_tmo();
    t_fb_lost();
    t_fb_stuck();
    t_dwell();
    t_floor();
    t_modes();
    stop_test();
  end
endmodule : tb_bsf_supervisor
`default_nettype wire
